// [rtl/adc_out_regs.vh]
`ifndef ADC_OUT_REGS_VH
`define ADC_OUT_REGS_VH

// system clock rate and derived figures
`define SYS_CLK_MHZ      20
`define SAMPLE_W         12
`define FIFO_DEPTH       16

// output modes
`define MODE_FULL_CMOS   2'h0
`define MODE_DDR_CMOS    2'h1
`define MODE_DDR_LVDS    2'h2

// clock control word fields
`define CCR_DCS_BIT      0
`define CCR_PHASE_LSB    1
`define CCR_PHASE_MSB    2
`define CCR_W            3

// forwarded clock: eight phase steps of 45 degrees per word
`define PH_STEPS         8
`define PH_W             3

// stabilizer lock length in encode cycles
`define DCS_LOCK_CYCLES  100
`define DCS_LOCK_W       7

// encode restart detection: silence time in ns and cycles
`define ENC_STOP_NS      2000
`define ENC_STOP_CYC     ((`ENC_STOP_NS * `SYS_CLK_MHZ) / 1000)
// single-ended detection: complement held low for this long
`define ENC_SE_NS        1000
`define ENC_SE_CYC       ((`ENC_SE_NS * `SYS_CLK_MHZ) / 1000)
`define ENC_CNT_W        8
// encode period drift tolerated before relock, in cycles
`define ENC_DRIFT_CYC    8'h01

// lvds current default code
`define LVDS_CUR_DEF     3'h4

`endif

// [rtl/adc_out_ctrl.v]
// What the document requires
// (R1) full-rate: twelve parallel bits, bit 11 msb
// (R2) full-rate data changes on clock falling edge
// (R3) complement clock is inverse of true clock
// (R4) range flag high on over or under range
// (R5) ddr cmos: even bits low, odd high
// (R6) ddr data changes on both clock edges
// (R7) output clock phase delayed by setting
// (R8) ddr lvds pairs plus differential range flag
// (R9) lvds current programmable, termination optional
// (R10) complement encode grounded selects single-ended
// (R11) stabilizer accepts 30-70% duty, outputs 50%
// (R12) stabilizer needs 100 encode cycles to lock
// (R13) stabilizer enable from register or cs pin
// (R14) system avoids stabilizer below 5 msps
// (R15) system keeps duty near 50% without stabilizer
// (R16) conversion starts on true encode rising edge; code uses complement fall unless single-ended
// (R17) parallel mode: cs high enables stabilizer
// (R18) parallel mode: sck selects full or lvds
// (R19) phase 0/45/90/135 only with stabilizer
// (R20) mode and phase change at sample boundary
`include "adc_out_regs.vh"

module sample_fifo #(
   parameter W     = 13,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire         clk_sys_i,
   input  wire         nrst_i,
   input  wire         in_valid_i,
   output wire         in_ready_o,
   input  wire [W-1:0] in_data_i,
   output wire         out_valid_o,
   input  wire         out_ready_i,
   output wire [W-1:0] out_data_o
);
   reg  [W-1:0] mem_ff [0:DEPTH-1];
   reg  [AW-1:0] wr_ff;
   reg  [AW-1:0] rd_ff;
   reg  [AW:0]   cnt_ff;
   wire          push;
   wire          pop;
   integer       i;

   assign in_ready_o  = (cnt_ff != DEPTH[AW:0]);
   assign out_valid_o = (cnt_ff != {(AW+1){1'b0}});
   assign out_data_o  = mem_ff[rd_ff];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   always @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         wr_ff  <= {AW{1'b0}};
         rd_ff  <= {AW{1'b0}};
         cnt_ff <= {(AW+1){1'b0}};
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem_ff[i] <= {W{1'b0}};
         end
      end else begin
         if (push) begin
            mem_ff[wr_ff] <= in_data_i;
            wr_ff         <= wr_ff + 1'b1;
         end
         if (pop) begin
            rd_ff <= rd_ff + 1'b1;
         end
         if (push & ~pop) begin
            cnt_ff <= cnt_ff + 1'b1;
         end else if (pop & ~push) begin
            cnt_ff <= cnt_ff - 1'b1;
         end
      end
   end
endmodule

module adc_out_ctrl #(
   parameter SW = `SAMPLE_W
) (
   input  wire              clk_sys_i,
   input  wire              nrst_i,
   input  wire              encode_true_i,
   input  wire              encode_comp_i,
   input  wire [SW-1:0]     conv_data_i,
   input  wire              conv_over_i,
   input  wire              conv_under_i,
   input  wire              prog_mode_pin_i,
   input  wire              cs_pin_i,
   input  wire              sck_pin_i,
   input  wire [`CCR_W-1:0] clock_ctrl_reg_i,
   input  wire [1:0]        out_mode_reg_i,
   input  wire [2:0]        lvds_cur_reg_i,
   input  wire              lvds_term_reg_i,
   output reg  [SW-1:0]     sample_bits_o,
   output reg  [SW/2-1:0]   paired_sample_lines_o,
   output reg  [SW/2-1:0]   paired_sample_lines_n_o,
   output reg               range_flag_o,
   output reg               range_flag_n_o,
   output reg               fwd_clk_true_o,
   output reg               fwd_clk_comp_o,
   output reg  [2:0]        lvds_cur_o,
   output reg               lvds_term_o,
   output reg  [1:0]        out_mode_o,
   output reg               enc_single_ended_o,
   output reg               dcs_locked_o,
   output reg               overrun_o
);
   localparam FW = SW + 1;

   // input synchronisers
   reg  [1:0]       enc_t_sync_ff;
   reg  [1:0]       enc_c_sync_ff;
   reg  [1:0]       par_sync_ff;
   reg  [1:0]       cs_sync_ff;
   reg  [1:0]       sck_sync_ff;
   reg  [SW-1:0]    dat_s1_ff;
   reg  [SW-1:0]    dat_s2_ff;
   reg  [1:0]       ovr_s1_ff;
   reg  [1:0]       ovr_s2_ff;
   reg              enc_t_d_ff;
   reg              enc_c_d_ff;

   always @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         enc_t_sync_ff <= 2'h0;
         enc_c_sync_ff <= 2'h0;
         par_sync_ff   <= 2'h0;
         cs_sync_ff    <= 2'h0;
         sck_sync_ff   <= 2'h0;
         dat_s1_ff     <= {SW{1'b0}};
         dat_s2_ff     <= {SW{1'b0}};
         ovr_s1_ff     <= 2'h0;
         ovr_s2_ff     <= 2'h0;
         enc_t_d_ff    <= 1'b0;
         enc_c_d_ff    <= 1'b0;
      end else begin
         enc_t_sync_ff <= {enc_t_sync_ff[0], encode_true_i};
         enc_c_sync_ff <= {enc_c_sync_ff[0], encode_comp_i};
         par_sync_ff   <= {par_sync_ff[0], prog_mode_pin_i};
         cs_sync_ff    <= {cs_sync_ff[0], cs_pin_i};
         sck_sync_ff   <= {sck_sync_ff[0], sck_pin_i};
         dat_s1_ff     <= conv_data_i;
         dat_s2_ff     <= dat_s1_ff;
         ovr_s1_ff     <= {conv_over_i, conv_under_i};
         ovr_s2_ff     <= ovr_s1_ff;
         enc_t_d_ff    <= enc_t_sync_ff[1];
         enc_c_d_ff    <= enc_c_sync_ff[1];
      end
   end

   // configuration source
   wire       par_mode = par_sync_ff[1];
   wire       dcs_en   = par_mode ? cs_sync_ff[1] :                // [R17]
                         clock_ctrl_reg_i[`CCR_DCS_BIT];           // [R13]
   wire [1:0] mode_req = par_mode ?                                // [R18]
                         (sck_sync_ff[1] ? `MODE_DDR_LVDS
                                         : `MODE_FULL_CMOS) :
                         out_mode_reg_i;
   wire [1:0] ph_req   = dcs_en ?                                  // [R19]
                         clock_ctrl_reg_i[`CCR_PHASE_MSB:`CCR_PHASE_LSB]
                         : 2'h0;

   // encode edge detection and single-ended detect
   reg  [`ENC_CNT_W-1:0] se_cnt_ff;
   reg                   se_ff;
   wire t_rise = enc_t_sync_ff[1] & ~enc_t_d_ff;
   wire c_fall = ~enc_c_sync_ff[1] & enc_c_d_ff;
   wire conv_start = se_ff ? t_rise : c_fall;                      // [R16]

   always @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         se_cnt_ff <= {`ENC_CNT_W{1'b0}};
         se_ff     <= 1'b0;
      end else if (enc_c_sync_ff[1]) begin
         se_cnt_ff <= {`ENC_CNT_W{1'b0}};
         se_ff     <= 1'b0;                                        // [R10]
      end else if (se_cnt_ff == `ENC_SE_CYC) begin
         se_ff     <= 1'b1;                                        // [R10]
      end else begin
         se_cnt_ff <= se_cnt_ff + 1'b1;
      end
   end

   // stabilizer lock: period watch and lock counter
   reg  [`ENC_CNT_W-1:0]  per_cnt_ff;
   reg  [`ENC_CNT_W-1:0]  per_last_ff;
   reg  [`DCS_LOCK_W-1:0] lock_cnt_ff;
   wire [`ENC_CNT_W-1:0]  per_diff = (per_cnt_ff > per_last_ff) ?
                          per_cnt_ff - per_last_ff :
                          per_last_ff - per_cnt_ff;
   wire enc_stopped = (per_cnt_ff == `ENC_STOP_CYC);
   wire freq_move   = conv_start & (per_diff > `ENC_DRIFT_CYC);
   wire locked      = (lock_cnt_ff == `DCS_LOCK_CYCLES);

   always @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         per_cnt_ff  <= {`ENC_CNT_W{1'b0}};
         per_last_ff <= {`ENC_CNT_W{1'b0}};
         lock_cnt_ff <= {`DCS_LOCK_W{1'b0}};
      end else begin
         if (conv_start) begin
            per_cnt_ff  <= {`ENC_CNT_W{1'b0}};
            per_last_ff <= per_cnt_ff;
         end else if (!enc_stopped) begin
            per_cnt_ff  <= per_cnt_ff + 1'b1;
         end
         if (!dcs_en || enc_stopped || freq_move) begin
            lock_cnt_ff <= {`DCS_LOCK_W{1'b0}};                    // [R12]
         end else if (conv_start && !locked) begin
            lock_cnt_ff <= lock_cnt_ff + 1'b1;                     // [R12]
         end
      end
   end

   // capture into fifo; stabilizer samples only once locked
   wire          fifo_in_rdy;
   wire          fifo_out_vld;
   wire [FW-1:0] fifo_out;
   wire          cap_ok = conv_start & (~dcs_en | locked);         // [R12]
   wire          rng    = ovr_s2_ff[1] | ovr_s2_ff[0];             // [R4]
   reg  [`PH_W-1:0] ph_ff;
   wire          bound  = (ph_ff == `PH_STEPS - 1);

   sample_fifo #(
      .W     (FW),
      .DEPTH (`FIFO_DEPTH),
      .AW    (4)
   ) u_fifo (
      .clk_sys_i   (clk_sys_i),
      .nrst_i      (nrst_i),
      .in_valid_i  (cap_ok),
      .in_ready_o  (fifo_in_rdy),
      .in_data_i   ({rng, dat_s2_ff}),
      .out_valid_o (fifo_out_vld),
      .out_ready_i (bound),
      .out_data_o  (fifo_out)
   );

   // word timing: eight steps per word, 50% clock
   reg  [FW-1:0] word_ff;
   reg  [1:0]    mode_ff;
   reg  [1:0]    phs_ff;
   wire [`PH_W-1:0] ph_sh = ph_ff - {1'b0, phs_ff};                // [R7] [R19]
   wire          clk_nxt = ph_sh[`PH_W-1];                         // [R11]
   wire          hi_half = ph_ff[`PH_W-1];
   wire [SW/2-1:0] even_b;
   wire [SW/2-1:0] odd_b;

   genvar g;
   generate
      for (g = 0; g < SW / 2; g = g + 1) begin : g_pair
         assign even_b[g] = word_ff[2*g];                          // [R5]
         assign odd_b[g]  = word_ff[2*g+1];                        // [R5]
      end
   endgenerate

   wire [SW/2-1:0] pair_nxt = hi_half ? odd_b : even_b;            // [R6]

   always @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         ph_ff     <= {`PH_W{1'b0}};
         word_ff   <= {FW{1'b0}};
         mode_ff   <= `MODE_FULL_CMOS;
         phs_ff    <= 2'h0;
         overrun_o <= 1'b0;
      end else begin
         ph_ff <= ph_ff + 1'b1;
         if (bound) begin
            mode_ff <= mode_req;                                   // [R20]
            phs_ff  <= ph_req;                                     // [R20]
            if (fifo_out_vld) begin
               word_ff <= fifo_out;
            end
         end
         overrun_o <= cap_ok & ~fifo_in_rdy;
      end
   end

   // output pins, all registered
   always @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         sample_bits_o           <= {SW{1'b0}};
         paired_sample_lines_o   <= {(SW/2){1'b0}};
         paired_sample_lines_n_o <= {(SW/2){1'b0}};
         range_flag_o            <= 1'b0;
         range_flag_n_o          <= 1'b0;
         fwd_clk_true_o          <= 1'b0;
         fwd_clk_comp_o          <= 1'b1;
         lvds_cur_o              <= `LVDS_CUR_DEF;
         lvds_term_o             <= 1'b0;
         out_mode_o              <= `MODE_FULL_CMOS;
         enc_single_ended_o      <= 1'b0;
         dcs_locked_o            <= 1'b0;
      end else begin
         fwd_clk_true_o     <= clk_nxt;                            // [R2] [R7]
         fwd_clk_comp_o     <= ~clk_nxt;                           // [R3]
         range_flag_o       <= word_ff[SW];                        // [R4]
         out_mode_o         <= mode_ff;
         enc_single_ended_o <= se_ff;
         dcs_locked_o       <= dcs_en & locked;
         case (mode_ff)
            `MODE_FULL_CMOS: begin
               sample_bits_o           <= word_ff[SW-1:0];         // [R1]
               paired_sample_lines_o   <= {(SW/2){1'b0}};
               paired_sample_lines_n_o <= {(SW/2){1'b0}};
               range_flag_n_o          <= 1'b0;
               lvds_term_o             <= 1'b0;
            end
            `MODE_DDR_CMOS: begin
               sample_bits_o           <= {SW{1'b0}};
               paired_sample_lines_o   <= pair_nxt;                // [R5]
               paired_sample_lines_n_o <= {(SW/2){1'b0}};
               range_flag_n_o          <= 1'b0;
               lvds_term_o             <= 1'b0;
            end
            `MODE_DDR_LVDS: begin
               sample_bits_o           <= {SW{1'b0}};
               paired_sample_lines_o   <= pair_nxt;                // [R8]
               paired_sample_lines_n_o <= ~pair_nxt;               // [R8]
               range_flag_n_o          <= ~word_ff[SW];            // [R8]
               lvds_cur_o              <= lvds_cur_reg_i;          // [R9]
               lvds_term_o             <= lvds_term_reg_i;         // [R9]
            end
            default: begin
               sample_bits_o           <= {SW{1'b0}};
               paired_sample_lines_o   <= {(SW/2){1'b0}};
               paired_sample_lines_n_o <= {(SW/2){1'b0}};
               range_flag_n_o          <= 1'b0;
               lvds_term_o             <= 1'b0;
            end
         endcase
      end
   end
endmodule

// [test/adc_out_ctrl_chk.sv]
module adc_out_ctrl_chk #(
   parameter SW = 12
) (
   input wire             clk_sys_i,
   input wire             nrst_i,
   input wire             encode_comp_i,
   input wire             prog_mode_pin_i,
   input wire             cs_pin_i,
   input wire [2:0]       clock_ctrl_reg_i,
   input wire [SW-1:0]    sample_bits_o,
   input wire [SW/2-1:0]  paired_sample_lines_o,
   input wire [SW/2-1:0]  paired_sample_lines_n_o,
   input wire             range_flag_o,
   input wire             range_flag_n_o,
   input wire             fwd_clk_true_o,
   input wire             fwd_clk_comp_o,
   input wire             lvds_term_o,
   input wire [1:0]       out_mode_o,
   input wire             enc_single_ended_o,
   input wire             overrun_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!nrst_i);
   // cycles the encode complement has stayed low
   reg  [5:0] se_cnt_ff;
   wire       m0 = out_mode_o == 2'h0;
   wire       lv = out_mode_o == 2'h2;
   always @(posedge clk_sys_i) begin
      if (!nrst_i || encode_comp_i)
         se_cnt_ff <= 6'h00;
      else if (se_cnt_ff != 6'h3f)
         se_cnt_ff <= se_cnt_ff + 6'h01;
   end
   // requested phase code and cycles since it last changed
   wire [1:0] ph = (prog_mode_pin_i ? cs_pin_i : clock_ctrl_reg_i[0]) ?
                   clock_ctrl_reg_i[2:1] : 2'h0;
   reg  [1:0] ph_last_ff;
   reg  [4:0] ph_age_ff;
   wire       ph_ok = ph_age_ff == 5'h1f;
   always @(posedge clk_sys_i) begin
      ph_last_ff <= ph;
      if (!nrst_i || ph != ph_last_ff)
         ph_age_ff <= 5'h00;
      else if (!ph_ok)
         ph_age_ff <= ph_age_ff + 5'h01;
   end
   property p_comp; fwd_clk_comp_o == !fwd_clk_true_o; endproperty
   a_comp: assert property (p_comp)
      else $error("clock pair not inverse");
   property p_ffall;
      m0 && $past(m0) && ph == 2'h0 && ph_ok && $changed(sample_bits_o)
         |-> $fell(fwd_clk_true_o);
   endproperty
   a_ffall: assert property (p_ffall)
      else $error("full-rate data moved off clock fall");
   property p_phase;
      m0 && $past(m0) && ph == 2'h1 && ph_ok && $changed(sample_bits_o)
         |-> fwd_clk_true_o ##1 $fell(fwd_clk_true_o);
   endproperty
   a_phase: assert property (p_phase)
      else $error("clock not delayed one step behind data");
   property p_ddr;
      !m0 && $stable(out_mode_o) && $changed(paired_sample_lines_o)
         |-> $changed(fwd_clk_true_o);
   endproperty
   a_ddr: assert property (p_ddr)
      else $error("ddr data moved off clock edge");
   property p_hi;
      $rose(fwd_clk_true_o) && ph_ok ##4 ph_ok |-> !fwd_clk_true_o &&
         $past(fwd_clk_true_o, 1) && $past(fwd_clk_true_o, 2) &&
         $past(fwd_clk_true_o, 3);
   endproperty
   a_hi: assert property (p_hi)
      else $error("clock high half not four cycles");
   property p_inv; lv && $past(lv) |-> range_flag_n_o == !range_flag_o &&
      paired_sample_lines_n_o == ~paired_sample_lines_o; endproperty
   a_inv: assert property (p_inv)
      else $error("lvds pair not inverse");
   property p_hold; $changed(out_mode_o) |=> $stable(out_mode_o)[*7];
   endproperty
   a_hold: assert property (p_hold)
      else $error("mode changed inside a word");
   property p_term; lvds_term_o |-> lv || $past(lv); endproperty
   a_term: assert property (p_term)
      else $error("termination outside lvds");
   property p_se; se_cnt_ff == 6'h28 |-> enc_single_ended_o; endproperty
   a_se: assert property (p_se)
      else $error("grounded complement not single-ended");
   c_full: cover property (m0 && $changed(sample_bits_o));
   c_lvds: cover property (lv && $changed(paired_sample_lines_o));
   c_ovr: cover property (overrun_o);
   c_phase: cover property (ph == 2'h1 && m0 && $changed(sample_bits_o));
endmodule

bind adc_out_ctrl adc_out_ctrl_chk #(.SW(SW)) i_adc_out_ctrl_chk (
   .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .encode_comp_i(encode_comp_i),
   .prog_mode_pin_i(prog_mode_pin_i), .cs_pin_i(cs_pin_i),
   .clock_ctrl_reg_i(clock_ctrl_reg_i),
   .sample_bits_o(sample_bits_o),
   .paired_sample_lines_o(paired_sample_lines_o),
   .paired_sample_lines_n_o(paired_sample_lines_n_o),
   .range_flag_o(range_flag_o), .range_flag_n_o(range_flag_n_o),
   .fwd_clk_true_o(fwd_clk_true_o), .fwd_clk_comp_o(fwd_clk_comp_o),
   .lvds_term_o(lvds_term_o), .out_mode_o(out_mode_o),
   .enc_single_ended_o(enc_single_ended_o), .overrun_o(overrun_o));

// [test/capture_model.sv]
module capture_model (
   input  wire        clk_sys_i,
   input  wire        nrst_i,
   input  wire        fwd_clk_i,
   input  wire [1:0]  mode_i,
   input  wire [11:0] bits_i,
   input  wire [5:0]  lines_i,
   input  wire        flag_i,
   output reg  [12:0] word_o,
   output reg         stb_o
);
   timeunit 1ns;
   timeprecision 1ns;
   reg        clk_ff;
   reg [5:0]  line_ff;
   reg [5:0]  even_ff;
   reg [11:0] bits_ff;
   reg        flag_ff;
   reg [12:0] last_ff;
   reg [12:0] w;
   integer    k;
   // latch on clock rise (full) or rise then fall (ddr)
   always @(posedge clk_sys_i) begin
      stb_o <= 1'b0;
      w = {flag_ff, bits_ff};
      for (k = 0; k < 6; k++) begin
         w[2*k] = mode_i == 2'h0 ? w[2*k] : even_ff[k];
         w[2*k+1] = mode_i == 2'h0 ? w[2*k+1] : line_ff[k];
      end
      if (!nrst_i)
         last_ff <= 13'h0000;
      else if (fwd_clk_i && !clk_ff && mode_i == 2'h0 ||
               !fwd_clk_i && clk_ff && mode_i != 2'h0) begin
         if (w != last_ff) begin
            word_o <= w;
            stb_o <= 1'b1;
         end
         last_ff <= w;
      end
      if (fwd_clk_i && !clk_ff)
         even_ff <= line_ff;
      clk_ff <= fwd_clk_i;
      line_ff <= lines_i;
      bits_ff <= bits_i;
      flag_ff <= flag_i;
   end
endmodule

// [test/adc_out_ctrl_tb_top.sv]
module adc_out_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
   $display("wrong value at %0t: %h %h", $time, g, e); end end
   reg clk_sys_i = 0, nrst_i = 0, et = 0, ec = 0, ov = 0, un = 0, pm = 0;
   reg cs = 0, sck = 0, term = 0, watch = 0, diff = 0, lock = 0, os = 0;
   reg [11:0] dat = 0;
   reg [2:0] ccr = 0, cur = 0;
   reg [1:0] mode = 0, em = 0;
   reg [31:0] seed = 32'h0000d3ab;
   reg [13:0] exp_q[$];
   reg [13:0] e;
   reg [12:0] prev = 0;
   reg [7:0] cfg[0:5] = '{8'h00, 8'h0f, 8'h10, 8'h8a, 8'he1, 8'h05};
   integer miscompares = 0, checks = 0, t;
   wire [11:0] sb;
   wire [5:0] pl, pn;
   wire [2:0] lc;
   wire [1:0] om;
   wire [12:0] cw;
   wire rf, rn, ft, fc, tm, se, lk, ovr, cst;
   always #25 clk_sys_i = ~clk_sys_i;
   adc_out_ctrl i_adc_out_ctrl (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
      .encode_true_i(et), .encode_comp_i(ec), .conv_data_i(dat),
      .conv_over_i(ov), .conv_under_i(un), .prog_mode_pin_i(pm),
      .cs_pin_i(cs), .sck_pin_i(sck), .clock_ctrl_reg_i(ccr),
      .out_mode_reg_i(mode), .lvds_cur_reg_i(cur), .lvds_term_reg_i(term),
      .sample_bits_o(sb), .paired_sample_lines_o(pl),
      .paired_sample_lines_n_o(pn), .range_flag_o(rf), .range_flag_n_o(rn),
      .fwd_clk_true_o(ft), .fwd_clk_comp_o(fc), .lvds_cur_o(lc),
      .lvds_term_o(tm), .out_mode_o(om), .enc_single_ended_o(se),
      .dcs_locked_o(lk), .overrun_o(ovr));
   capture_model i_capture_model (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
      .fwd_clk_i(ft), .mode_i(em), .bits_i(sb), .lines_i(pl), .flag_i(rf),
      .word_o(cw), .stb_o(cst));
   function [31:0] xs(input [31:0] x);
      reg [31:0] y;
      begin
         y = x ^ (x << 13);
         y = y ^ (y >> 17);
         xs = y ^ (y << 5);
      end
   endfunction
   // one encode period of 2*hp cycles per sample, 50% duty
   task send(input integer n, input integer hp, input reg care);
      integer i;
      reg [12:0] v;
      for (i = 0; i < n; i++) begin
         seed = xs(seed);
         v = seed[12:0] ^ {13{prev == seed[12:0]}};
         prev = v;
         @(negedge clk_sys_i);
         dat = v[11:0];
         ov = v[12] & seed[20];
         un = v[12] & !seed[20];
         et = 0;
         ec = diff;
         exp_q.push_back({care, v});
         repeat (hp) @(negedge clk_sys_i);
         et = 1;
         ec = 0;
         repeat (hp - 1) @(negedge clk_sys_i);
      end
      @(negedge clk_sys_i);
      et = 0;
      ec = diff;
   endtask
   task tally_and_finish;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // skip lost filler words, compare every marked word in order
   always @(negedge clk_sys_i) begin
      if (ovr)
         os = 1;
      if (cst && watch) begin
         while (exp_q.size() > 0 && !exp_q[0][13] && exp_q[0][12:0] !== cw)
            void'(exp_q.pop_front());
         e = exp_q.size() > 0 ? exp_q.pop_front() : 14'hx;
         if (e[13] !== 1'b0)
            `CHK(cw, e[12:0])
      end
   end
   initial begin
      #1000000;
      miscompares++;
      tally_and_finish;
   end
   initial begin
      repeat (4) @(negedge clk_sys_i);
      `CHK(fc, 1'b1)
      `CHK(lc, 3'h4)
      nrst_i = 1;
      for (t = 0; t < 7; t++) begin
         watch = 0;
         os = 0;
         seed = xs(seed);
         {pm, sck, cs, mode, ccr[0], diff, lock} = t < 6 ? cfg[t] : 8'h10;
         {term, cur} = seed[3:0];
         em = pm ? {sck, 1'b0} : mode;
         ccr[2:1] = em == 2'h0 ? 2'h1 : 2'h0;
         ec = diff;
         repeat (60) @(negedge clk_sys_i);
         watch = 1;
         if (lock) begin
            send(98, 4, 0);
            `CHK(lk, 1'b0)
            send(4, 4, 0);
         end
         if (t == 6) begin
            send(40, 2, 0);
            repeat (150) @(negedge clk_sys_i);
            `CHK(os, 1'b1)
         end
         send(12, 4, 1);
         repeat (40) @(negedge clk_sys_i);
         `CHK(exp_q.size(), 0)
         `CHK(om, em)
         `CHK(se, !diff)
         `CHK(lk, lock)
         `CHK(tm, term && em == 2'h2)
         if (em == 2'h2)
            `CHK(lc, cur)
         $display("test %0d done", t);
      end
      tally_and_finish;
   end
endmodule
